// [design/ddc_pkg.sv]
// Purpose: Constants and types for the display DMA channel
// Assumes: One 250 MHz system clock, AHB-Lite register access
// Notes: Register offsets are byte addresses on 32-bit words
package ddc_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PACKED = 8'h08;
   localparam logic [7:0] ADDR_CUR = 8'h0C;
   localparam logic [7:0] ADDR_BLK_BASE = 8'h10;
   localparam logic [7:0] ADDR_BLK_STEP = 8'h20;
   localparam logic [7:0] OFF_TOP = 8'h00;
   localparam logic [7:0] OFF_PARAM = 8'h04;
   localparam logic [7:0] OFF_COUNT = 8'h08;
   localparam logic [7:0] OFF_EIDX = 8'h0C;
   localparam logic [7:0] OFF_FIDX = 8'h10;
   localparam logic [7:0] OFF_BSIZE = 8'h14;
   localparam int CTL_EN = 0;
   localparam int CTL_DUAL = 1;
   localparam int CTL_START2 = 2;
   localparam int CTL_MODE = 3;
   localparam int CTL_SRC = 5;
   localparam int CTL_DST_EXT = 6;
   localparam int CTL_SYNC = 7;
   localparam int CTL_MAP_OFF = 8;
   localparam int CTL_W = 9;
   localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;
   localparam int STATUS_W = 7;
   localparam int ST_FRAME = 0;
   localparam int ST_BLK1 = 1;
   localparam int ST_BLK2 = 2;
   localparam logic [STATUS_W-1:0] STATUS_RST = 7'h00;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [1:0] ES_CODE8 = 2'h0;
   localparam logic [1:0] ES_CODE16 = 2'h1;
   localparam logic [1:0] ES_CODE32 = 2'h2;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;
   localparam logic [FIFO_AW:0] BURST_LEN = 4'h4;
   localparam logic [1:0] BURST_LAST = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
   typedef enum logic [1:0] {MODE_POST, MODE_SINGLE, MODE_DOUBLE} ddc_mode_type;
   typedef enum logic [1:0] {ENG_IDLE, ENG_REQ, ENG_DATA} ddc_eng_type;
endpackage

// [design/ddc_top.sv]
// Purpose: Display DMA channel, memory video buffer to LCD stream
// Assumes: Software programs blocks before setting enable
// Notes: One read request outstanding at a time
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ddc_top import ddc_pkg::*; (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic mem_req0,
   output logic mem_req1,
   output logic [31:0] mem_addr,
   output logic [1:0] mem_size,
   output logic mem_burst,
   input wire logic mem_gnt0,
   input wire logic mem_gnt1,
   input wire logic mem_rvalid0,
   input wire logic mem_rvalid1,
   input wire logic [31:0] mem_rdata0,
   input wire logic [31:0] mem_rdata1,
   output logic [31:0] ext_lcd_data,
   output logic ext_lcd_valid,
   input wire logic ext_lcd_ready,
   input wire logic ext_lcd_dreq,
   output logic [15:0] int_lcd_data,
   output logic int_lcd_valid,
   input wire logic int_lcd_ready,
   input wire logic [STATUS_W-1:0] lch12_status,
   input wire logic lch12_irq,
   output logic irq_line_shared,
   output logic irq_line_display
);
   // Bus slave: reads take one wait state so a preceding write is always visible
   logic dph_wr_r, dph_rd_r, rd_done_r;
   logic [7:0] wa_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_mux;
   wire acc = hsel & hready & htrans[1];
   wire wr_go = dph_wr_r & hready;
   wire rd_cap = dph_rd_r & ~rd_done_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dph_wr_r <= 1'b0;
         dph_rd_r <= 1'b0;
         rd_done_r <= 1'b0;
         wa_r <= 8'h00;
         hrdata_r <= REG_RST;
      end else if (hready) begin
         dph_wr_r <= acc & hwrite;
         dph_rd_r <= acc & ~hwrite;
         rd_done_r <= 1'b0;
         if (acc) begin
            wa_r <= {haddr[7:2], 2'b00};
         end
      end else if (rd_cap) begin
         hrdata_r <= rd_mux;
         rd_done_r <= 1'b1;
      end
   end

   assign hreadyout = ~rd_cap;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_r;

   // Control and per-block configuration
   logic [CTL_W-1:0] ctrl_r;
   logic [STATUS_W-1:0] status_r;
   logic [31:0] top_r [2];
   logic [1:0] esc_r [2];
   logic [15:0] en_r [2];
   logic [15:0] fn_r [2];
   logic [15:0] ei_r [2];
   logic [31:0] fi_r [2];
   logic [15:0] ecnt_r [2];
   logic [15:0] fcnt_r [2];
   logic [31:0] blk_rd [2];
   logic [2:0] es3 [2];
   logic [31:0] addr_r;
   logic blk_r, run_r, port_r, burst_r;
   logic [1:0] beats_r;
   ddc_eng_type st_r, st_nxt;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_r <= CTRL_RST;
      end else if (wr_go && wa_r == ADDR_CTRL) begin
         ctrl_r <= hwdata[CTL_W-1:0];
      end
   end

   wire run_en = ctrl_r[CTL_EN];
   wire dual = ctrl_r[CTL_DUAL];
   wire src_port = ctrl_r[CTL_SRC];
   wire dst_ext = ctrl_r[CTL_DST_EXT];
   wire sync_en = ctrl_r[CTL_SYNC];
   wire map_off = ctrl_r[CTL_MAP_OFF];
   wire start_blk = dual & ctrl_r[CTL_START2];
   wire start = run_en & ~run_r;
   wire ddc_mode_type mode = ddc_mode_type'(ctrl_r[CTL_MODE+1:CTL_MODE]);

   // Active block view
   wire [15:0] act_ecnt = ecnt_r[blk_r];
   wire [15:0] act_fcnt = fcnt_r[blk_r];
   wire [15:0] act_en = en_r[blk_r];
   wire [31:0] act_top = top_r[blk_r];
   wire [31:0] act_es32 = {29'h0, es3[blk_r]};
   wire [31:0] act_ei32 = {{16{ei_r[blk_r][15]}}, ei_r[blk_r]};
   wire [31:0] act_fi = fi_r[blk_r];
   wire last_e = act_ecnt <= 16'h0001;
   wire last_f = act_fcnt <= 16'h0001;
   wire blk_end = last_e & last_f;
   wire blk_nxt = (blk_end & dual) ? ~blk_r : blk_r;
   // Stride n elements gives index (n-1)*ES+1, so each step is ES+index-1
   wire [31:0] estep = (mode == MODE_POST) ? act_es32 : act_es32 + act_ei32 - 32'h1;
   wire [31:0] fstep = (mode == MODE_DOUBLE) ? act_es32 + act_fi - 32'h1 : estep;
   wire [31:0] addr_adv = blk_end ? top_r[blk_nxt] : (last_e ? addr_r + fstep : addr_r + estep);

   wire gnt_sel = port_r ? mem_gnt1 : mem_gnt0;
   wire rvalid_sel = port_r ? mem_rvalid1 : mem_rvalid0;
   wire [31:0] rdata_sel = port_r ? mem_rdata1 : mem_rdata0;
   wire beat = (st_r == ENG_DATA) & rvalid_sel;

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_blk
         localparam logic [7:0] BA = ADDR_BLK_BASE + ADDR_BLK_STEP * 8'(b);
         wire load = (start & (start_blk == 1'(b))) | (beat & blk_end & (blk_nxt == 1'(b)));
         wire step = beat & ~blk_end & (blk_r == 1'(b));
         wire [31:0] bsize = 32'({29'h0, es3[b]} * {16'h0, en_r[b]} * {16'h0, fn_r[b]});
         assign es3[b] = (esc_r[b] == ES_CODE8) ? 3'h1 : ((esc_r[b] == ES_CODE16) ? 3'h2 : 3'h4);
         assign blk_rd[b] = (wa_r == BA + OFF_TOP) ? top_r[b] :
                            (wa_r == BA + OFF_PARAM) ? {30'h0, esc_r[b]} :
                            (wa_r == BA + OFF_COUNT) ? {fn_r[b], en_r[b]} :
                            (wa_r == BA + OFF_EIDX) ? {16'h0, ei_r[b]} :
                            (wa_r == BA + OFF_FIDX) ? fi_r[b] :
                            (wa_r == BA + OFF_BSIZE) ? bsize : REG_RST;
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               top_r[b] <= REG_RST;
               esc_r[b] <= ES_CODE8;
               en_r[b] <= 16'h0000;
               fn_r[b] <= 16'h0000;
               ei_r[b] <= 16'h0000;
               fi_r[b] <= REG_RST;
            end else if (wr_go) begin
               if (wa_r == BA + OFF_TOP) top_r[b] <= hwdata;
               if (wa_r == BA + OFF_PARAM) esc_r[b] <= hwdata[1:0];
               if (wa_r == BA + OFF_COUNT) begin
                  en_r[b] <= hwdata[15:0];
                  fn_r[b] <= hwdata[31:16];
               end
               if (wa_r == BA + OFF_EIDX) ei_r[b] <= hwdata[15:0];
               if (wa_r == BA + OFF_FIDX) fi_r[b] <= hwdata;
            end
         end
         // Counters of an idle block hold; they reload when it becomes active
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               ecnt_r[b] <= 16'h0000;
               fcnt_r[b] <= 16'h0000;
            end else if (load) begin
               ecnt_r[b] <= en_r[b];
               fcnt_r[b] <= fn_r[b];
            end else if (step) begin
               if (last_e) begin
                  ecnt_r[b] <= en_r[b];
                  fcnt_r[b] <= fcnt_r[b] - 16'h0001;
               end else begin
                  ecnt_r[b] <= ecnt_r[b] - 16'h0001;
               end
            end
         end
      end
   endgenerate

   // FIFO
   logic [31:0] fifo_mem_r [FIFO_DEPTH];
   logic [FIFO_AW:0] wp_r, rp_r;
   logic half_r;
   wire [FIFO_AW:0] fifo_cnt = wp_r - rp_r;
   wire [FIFO_AW:0] fifo_free = FIFO_DEPTH[FIFO_AW:0] - fifo_cnt;
   wire fifo_empty = fifo_cnt == '0;
   wire fifo_full = fifo_cnt[FIFO_AW];
   // Room for a whole burst is reserved before asking, so beats never meet a full FIFO
   wire room = fifo_free > BURST_LEN;

   // Pacing from the external display pin
   logic dreq_m_r, dreq_s_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dreq_m_r <= 1'b0;
         dreq_s_r <= 1'b0;
      end else begin
         dreq_m_r <= ext_lcd_dreq;
         dreq_s_r <= dreq_m_r;
      end
   end
   wire sync_ok = ~(dst_ext & sync_en) | dreq_s_r;

   // Read engine
   wire burst_ok = (mode == MODE_POST) & (esc_r[blk_r] == ES_CODE32) &
                   (act_ecnt >= 16'h0004) & (addr_r[3:0] == 4'h0);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ENG_IDLE: begin
            if (run_r & room & sync_ok) st_nxt = ENG_REQ;
         end
         ENG_REQ: begin
            if (gnt_sel) st_nxt = ENG_DATA;
         end
         ENG_DATA: begin
            if (beat && beats_r == 2'h0) st_nxt = ENG_IDLE;
         end
         default: st_nxt = ENG_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= ENG_IDLE;
         run_r <= 1'b0;
         addr_r <= REG_RST;
         blk_r <= 1'b0;
         port_r <= 1'b0;
         burst_r <= 1'b0;
         beats_r <= 2'h0;
      end else begin
         st_r <= st_nxt;
         run_r <= run_en;
         if (st_r == ENG_IDLE && st_nxt == ENG_REQ) begin
            port_r <= src_port;
            burst_r <= burst_ok;
            beats_r <= burst_ok ? BURST_LAST : 2'h0;
         end
         if (start) begin
            addr_r <= top_r[start_blk];
            blk_r <= start_blk;
         end else if (beat) begin
            addr_r <= addr_adv;
            blk_r <= blk_nxt;
            beats_r <= beats_r - 2'h1;
         end
      end
   end

   assign mem_req0 = (st_r == ENG_REQ) & ~port_r;
   assign mem_req1 = (st_r == ENG_REQ) & port_r;
   assign mem_addr = addr_r;
   assign mem_size = esc_r[blk_r];
   assign mem_burst = (st_r == ENG_REQ) & burst_r;

   // Packer: elements are gathered little-endian into words, so order is kept
   logic [31:0] acc_r;
   logic [1:0] fill_r;
   wire [31:0] elem_sh = rdata_sel >> {addr_r[1:0], 3'b000};
   wire [31:0] elem_m = (es3[blk_r] == 3'h1) ? {24'h0, elem_sh[7:0]} :
                        (es3[blk_r] == 3'h2) ? {16'h0, elem_sh[15:0]} : elem_sh;
   wire [31:0] packed_w = acc_r | (elem_m << {fill_r, 3'b000});
   wire [2:0] fill_sum = {1'b0, fill_r} + es3[blk_r];
   // A word element landing on a half-filled word spills its upper bytes into the next word
   wire [5:0] carry_sh = 6'h20 - {1'b0, fill_r, 3'b000};
   wire [31:0] carry_w = elem_m >> carry_sh;
   wire fifo_push = beat & fill_sum[2];
   wire ext_pop = dst_ext & ext_lcd_valid & ext_lcd_ready;
   wire int_take = ~dst_ext & int_lcd_valid & int_lcd_ready;
   wire fifo_pop = ext_pop | (int_take & half_r);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         acc_r <= REG_RST;
         fill_r <= 2'h0;
      end else if (beat) begin
         acc_r <= fill_sum[2] ? carry_w : packed_w;
         fill_r <= fill_sum[1:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         half_r <= 1'b0;
      end else begin
         if (fifo_push) wp_r <= wp_r + 1'b1;
         if (fifo_pop) rp_r <= rp_r + 1'b1;
         if (int_take) half_r <= ~half_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (fifo_push) fifo_mem_r[wp_r[FIFO_AW-1:0]] <= packed_w;
   end

   // Display side pulls from the FIFO head; it supplies no address
   wire [31:0] head = fifo_mem_r[rp_r[FIFO_AW-1:0]];
   assign ext_lcd_data = head;
   assign int_lcd_data = half_r ? head[31:16] : head[15:0];
   assign ext_lcd_valid = dst_ext & ~fifo_empty;
   assign int_lcd_valid = ~dst_ext & ~fifo_empty;

   // Status: a set in the clearing cycle survives
   wire rd_clr = rd_cap & (wa_r == ADDR_STATUS || wa_r == ADDR_PACKED);
   logic [STATUS_W-1:0] st_set;
   assign st_set = {4'h0, beat & blk_end & blk_r, beat & blk_end & ~blk_r, beat & last_e};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         status_r <= STATUS_RST;
      end else begin
         status_r <= (status_r & ~(rd_clr ? status_r : STATUS_RST)) | st_set;
      end
   end

   wire disp_irq = |status_r;
   assign irq_line_display = map_off & disp_irq;
   assign irq_line_shared = lch12_irq | (~map_off & disp_irq);

   wire [31:0] packed_st = {18'h0, lch12_status, status_r};
   assign rd_mux = (wa_r == ADDR_CTRL) ? {23'h0, ctrl_r} :
                   (wa_r == ADDR_STATUS) ? {25'h0, status_r} :
                   (wa_r == ADDR_PACKED) ? packed_st :
                   (wa_r == ADDR_CUR) ? addr_r :
                   (wa_r >= ADDR_BLK_BASE + ADDR_BLK_STEP) ? blk_rd[1] : blk_rd[0];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_port;
      $rose(mem_req0 | mem_req1) |-> mem_req1 == $past(src_port);
   endproperty
   a_port: assert property (p_port) else $error("read sent to wrong port");
   property p_no_push_full;
      fifo_push |-> !fifo_full;
   endproperty
   a_no_push_full: assert property (p_no_push_full) else $error("push into full fifo");
   property p_empty_quiet;
      fifo_empty |-> !ext_lcd_valid && !int_lcd_valid;
   endproperty
   a_empty_quiet: assert property (p_empty_quiet) else $error("display valid while empty");
   property p_elem_dec;
      beat && !last_e |=> act_ecnt == $past(act_ecnt) - 16'h0001;
   endproperty
   a_elem_dec: assert property (p_elem_dec) else $error("element counter not decremented");
   property p_frame_dec;
      beat && last_e && !last_f |=> act_fcnt == $past(act_fcnt) - 16'h0001 && act_ecnt == $past(act_en);
   endproperty
   a_frame_dec: assert property (p_frame_dec) else $error("frame advance wrong");
   property p_wrap;
      beat && blk_end && !dual |=> addr_r == $past(act_top) && blk_r == $past(blk_r);
   endproperty
   a_wrap: assert property (p_wrap) else $error("single block did not wrap to top");
   property p_switch;
      beat && blk_end && dual |=> blk_r != $past(blk_r) && addr_r == act_top;
   endproperty
   a_switch: assert property (p_switch) else $error("dual block did not switch");
   property p_single_step;
      beat && !last_e && mode == MODE_SINGLE |=> addr_r == $past(addr_r) + $past(act_es32) + $past(act_ei32) - 32'h1;
   endproperty
   a_single_step: assert property (p_single_step) else $error("element index step wrong");
   property p_double_frame;
      beat && last_e && !last_f && mode == MODE_DOUBLE |=> addr_r == $past(addr_r) + $past(act_es32) + $past(act_fi) - 32'h1;
   endproperty
   a_double_frame: assert property (p_double_frame) else $error("frame index step wrong");
   property p_burst;
      mem_burst |-> mem_size == ES_CODE32 && mode == MODE_POST && mem_addr[3:0] == 4'h0;
   endproperty
   a_burst: assert property (p_burst) else $error("illegal burst");
   property p_sync;
      st_r == ENG_IDLE && st_nxt == ENG_REQ && dst_ext && sync_en |-> dreq_s_r;
   endproperty
   a_sync: assert property (p_sync) else $error("read issued without display request");
   property p_irq_map;
      disp_irq && !lch12_irq |-> irq_line_display != irq_line_shared;
   endproperty
   a_irq_map: assert property (p_irq_map) else $error("interrupt on wrong line");
   property p_int_half;
      int_take && !half_r |=> half_r && rp_r == $past(rp_r);
   endproperty
   a_int_half: assert property (p_int_half) else $error("internal half word advanced fifo");
endmodule
`default_nettype wire

// [testbench/ddc_far_model.sv]
// Purpose: Far side model, two memory ports and both display sinks
// Assumes: Grants, beats and display readies come after random stalls
// Notes: Idle read data flips every cycle so stale words never match
`timescale 1ns/1ps
`default_nettype none
module ddc_far_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mem_req0,
   input wire logic mem_req1,
   input wire logic [31:0] mem_addr,
   input wire logic mem_burst,
   output logic mem_gnt0,
   output logic mem_gnt1,
   output logic mem_rvalid0,
   output logic mem_rvalid1,
   output logic [31:0] mem_rdata0,
   output logic [31:0] mem_rdata1,
   output logic ext_lcd_ready,
   output logic ext_lcd_dreq,
   output logic int_lcd_ready
);
   logic [2:0] beats_r;
   logic [31:0] addr_r;
   logic port_r;
   logic go;
   // Word content depends on the address only, so the bench can predict it
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[15:2], 2'h0, ~a[15:2], 2'h3};
   endfunction
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {mem_gnt0, mem_gnt1, mem_rvalid0, mem_rvalid1} <= 4'h0;
         {ext_lcd_ready, ext_lcd_dreq, int_lcd_ready} <= 3'h0;
         mem_rdata0 <= 32'h0;
         mem_rdata1 <= 32'h0;
         beats_r <= 3'h0;
         addr_r <= 32'h0;
         port_r <= 1'b0;
      end else begin
         go = ($urandom_range(0, 3) != 0);
         mem_gnt0 <= 1'b0;
         mem_gnt1 <= 1'b0;
         mem_rvalid0 <= go && beats_r != 3'h0 && !port_r;
         mem_rvalid1 <= go && beats_r != 3'h0 && port_r;
         mem_rdata0 <= (go && beats_r != 3'h0 && !port_r) ? word_at(addr_r) : ~mem_rdata0;
         mem_rdata1 <= (go && beats_r != 3'h0 && port_r) ? word_at(addr_r) : ~mem_rdata1;
         if (go && beats_r != 3'h0) begin
            beats_r <= beats_r - 3'h1;
            addr_r <= addr_r + 32'h4;
         end else if (go && beats_r == 3'h0 && (mem_req0 | mem_req1) && !(mem_gnt0 | mem_gnt1)) begin
            mem_gnt0 <= mem_req0;
            mem_gnt1 <= mem_req1 & !mem_req0;
            port_r <= !mem_req0;
            beats_r <= mem_burst ? 3'h4 : 3'h1;
            addr_r <= mem_addr;
         end
         ext_lcd_ready <= ($urandom_range(0, 3) != 0);
         int_lcd_ready <= ($urandom_range(0, 3) != 0);
         ext_lcd_dreq <= 1'($urandom_range(0, 1));
      end
   end
endmodule
`default_nettype wire

// [testbench/display_dma_channel_tb_top.sv]
// Purpose: Self-checking bench for the display DMA channel
// Assumes: Far side model stalls at random; fixed seed
// Notes: Expected byte stream is rebuilt from the address stepping
`timescale 1ns/1ps
`default_nettype none
module display_dma_channel_tb_top import ddc_pkg::*; ;
   typedef struct {int mode, dual, start2, ext, src, sync, mapoff;} ddc_cfg_type;
   typedef struct {int top, esc, en, fn, est, fst;} ddc_blk_type;
   logic clk_sys = 1'b0, rst = 1'b0, hsel = 1'b0, hwrite = 1'b0, lch12_irq = 1'b0, mon = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [6:0] lch12_status = 7'h0;
   logic hready, hreadyout, mem_req0, mem_req1, mem_burst, mem_gnt0, mem_gnt1, mem_rvalid0, mem_rvalid1;
   logic [31:0] hrdata, mem_addr, mem_rdata0, mem_rdata1, ext_lcd_data;
   logic [15:0] int_lcd_data;
   logic ext_lcd_valid, ext_lcd_ready, ext_lcd_dreq, int_lcd_valid, int_lcd_ready, irq_line_shared, irq_line_display;
   int n_errors = 0, check_count = 0, out_cnt = 0;
   ddc_cfg_type c;
   ddc_blk_type bk[2];
   logic [7:0] expq[$];
   assign hready = hreadyout;
   always #2 clk_sys = ~clk_sys;
   ddc_top ddc_top_inst (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
      .hresp(), .hrdata, .mem_req0, .mem_req1, .mem_addr, .mem_size(), .mem_burst, .mem_gnt0, .mem_gnt1,
      .mem_rvalid0, .mem_rvalid1, .mem_rdata0, .mem_rdata1, .ext_lcd_data, .ext_lcd_valid, .ext_lcd_ready,
      .ext_lcd_dreq, .int_lcd_data, .int_lcd_valid, .int_lcd_ready, .lch12_status, .lch12_irq, .irq_line_shared,
      .irq_line_display);
   ddc_far_model ddc_far_model_inst (.clk_sys, .rst, .mem_req0, .mem_req1, .mem_addr, .mem_burst, .mem_gnt0,
      .mem_gnt1, .mem_rvalid0, .mem_rvalid1, .mem_rdata0, .mem_rdata1, .ext_lcd_ready, .ext_lcd_dreq,
      .int_lcd_ready);
   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      chk(32'h0, 32'h1);
      print_verdict();
   endtask
   // Master holds each phase until hready is seen high at a rising edge
   task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ad};
      hwrite <= wr;
      do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 64);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1 && ++n < 64);
      rd = hrdata;
      if (n >= 64) tmo();
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, ad, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      ahb(1'b0, ad, 32'h0, x);
      chk(x & m, e);
   endtask
   function automatic logic [7:0] ba(input int b, input logic [7:0] off);
      return ADDR_BLK_BASE + 8'(b) * ADDR_BLK_STEP + off;
   endfunction
   // Missing bytes come back unknown so a short stream never matches
   function automatic logic [31:0] take(input int n);
      logic [31:0] w;
      w = 32'h0;
      for (int i = 0; i < n; i++) w[8 * i +: 8] = expq.size() > 0 ? expq.pop_front() : 8'hXX;
      return w;
   endfunction
   task automatic gen(input int nbytes);
      int b, ec, fc, es;
      logic [31:0] a, w;
      b = c.start2;
      a = 32'(bk[b].top);
      ec = bk[b].en;
      fc = bk[b].fn;
      while (expq.size() < nbytes) begin
         es = 1 << bk[b].esc;
         w = ddc_far_model_inst.word_at(a) >> (8 * a[1:0]);
         for (int i = 0; i < es; i++) expq.push_back(w[8 * i +: 8]);
         if (ec > 1) begin
            ec--;
            a = a + 32'(c.mode == 0 ? es : es + ((bk[b].est - 1) * es + 1) - 1);
         end else if (fc > 1) begin
            ec = bk[b].en;
            fc--;
            a = a + 32'(c.mode == 2 ? es + ((bk[b].fst - 1) * es + 1) - 1 :
               c.mode == 1 ? es + ((bk[b].est - 1) * es + 1) - 1 : es);
         end else begin
            b = c.dual != 0 ? 1 - b : b;
            a = 32'(bk[b].top);
            ec = bk[b].en;
            fc = bk[b].fn;
         end
      end
   endtask
   always @(posedge clk_sys) begin
      if (mon) begin
         if (ext_lcd_valid === 1'b1 && ext_lcd_ready) begin
            chk(ext_lcd_data, take(4));
            out_cnt++;
         end
         if (int_lcd_valid === 1'b1 && int_lcd_ready) begin
            chk({16'h0, int_lcd_data}, take(2));
            out_cnt++;
         end
         if ((c.ext != 0 ? int_lcd_valid : ext_lcd_valid) !== 1'b0) chk(32'h1, 32'h0);
      end
   end
   task automatic do_reset;
      mon <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      expq.delete();
      out_cnt = 0;
      @(posedge clk_sys);
   endtask
   task automatic run(input int target);
      int n, es, ctl;
      do_reset();
      lch12_status <= 7'($urandom_range(0, 127));
      lch12_irq <= 1'($urandom_range(0, 1));
      for (int b = 0; b < 2; b++) begin
         es = 1 << bk[b].esc;
         wr(ba(b, OFF_TOP), 32'(bk[b].top));
         wr(ba(b, OFF_PARAM), 32'(bk[b].esc));
         wr(ba(b, OFF_COUNT), {16'(bk[b].fn), 16'(bk[b].en)});
         wr(ba(b, OFF_EIDX), {16'h0, 16'((bk[b].est - 1) * es + 1)});
         wr(ba(b, OFF_FIDX), 32'((bk[b].fst - 1) * es + 1));
         rd_chk(ba(b, OFF_BSIZE), 32'hFFFFFFFF, 32'(es * bk[b].en * bk[b].fn));
      end
      ctl = c.dual << CTL_DUAL | c.start2 << CTL_START2 | c.mode << CTL_MODE | c.src << CTL_SRC |
         c.ext << CTL_DST_EXT | c.sync << CTL_SYNC | c.mapoff << CTL_MAP_OFF;
      gen(target * (c.ext != 0 ? 4 : 2) + 64);
      mon <= 1'b1;
      wr(ADDR_CTRL, 32'(ctl | 1));
      n = 0;
      while (out_cnt < target && n++ < 20000) @(posedge clk_sys);
      if (n >= 20000) tmo();
      wr(ADDR_CTRL, 32'(ctl));
      repeat (40) @(posedge clk_sys);
      chk({30'h0, irq_line_shared, irq_line_display}, {30'h0, lch12_irq | (c.mapoff == 0), c.mapoff != 0});
      rd_chk(ADDR_PACKED, 32'hFFFFFF81 | 32'(2 << c.start2),
         {18'h0, lch12_status, 7'h0} | 32'h1 | 32'(2 << c.start2));
      rd_chk(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      chk({31'h0, irq_line_display}, 32'h0);
   endtask
   initial begin
      void'($urandom(32'h6F671099));
      do_reset();
      rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      rd_chk(ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
      wr(8'hFC, 32'hFFFFFFFF);
      rd_chk(8'hFC, 32'hFFFFFFFF, 32'h0);
      rd_chk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
      // Post increment with bursts, wrapping to the same top
      c = '{0, 0, 0, 1, 0, 0, 0};
      bk[0] = '{$urandom_range(1, 60) * 256, 2, 8, 2, 1, 1};
      bk[1] = bk[0];
      run(40);
      // Single index, dual blocks of mixed width, second block first
      c = '{1, 1, 1, 0, 1, 0, 0};
      bk[0] = '{$urandom_range(1, 60) * 256 + 2, 1, 3, 2, 2, 2};
      bk[1] = '{$urandom_range(61, 120) * 256 + 1, 0, 4, 2, 3, 3};
      run(40);
      // Column walk for rotation, paced by the external display
      c = '{2, 1, 0, 1, 0, 1, 1};
      bk[0] = '{$urandom_range(1, 60) * 256, 1, 3, 4, 4, -7};
      bk[1] = '{$urandom_range(61, 120) * 256 + 12, 2, 2, 2, 3, -2};
      run(30);
      repeat (3) begin
         c = '{$urandom_range(0, 2), $urandom_range(0, 1), 0, 0, $urandom_range(0, 1), 0, $urandom_range(0, 1)};
         for (int b = 0; b < 2; b++) bk[b] = '{$urandom_range(1, 120) * 256 + 64, $urandom_range(0, 2),
            2 * $urandom_range(1, 2), $urandom_range(1, 3), $urandom_range(1, 3), int'($urandom_range(0, 3)) - 1};
         run(40);
      end
      print_verdict();
   end
endmodule
`default_nettype wire
